/* File: core/flash_cfg2_pkg.sv */
// constants, types and helpers for the second flash configuration register
package flash_cfg2_pkg;
    localparam logic [3:0] REG_NONVOLATILE_OFS = 4'h0;
    localparam logic [3:0] REG_VOLATILE_OFS = 4'h4;
    localparam logic [3:0] REG_STATUS_OFS = 4'h8;

    localparam int ADDR_LEN_BIT = 7;
    localparam int ALL_QUAD_BIT = 6;
    localparam int RESET_SHARE_BIT = 5;
    localparam int RESERVED_BIT = 4;
    localparam int LATENCY_LSB = 0;
    localparam int LATENCY_W = 4;

    localparam int STAT_RESET_SEEN_BIT = 0;
    localparam int STAT_CS_BIT = 1;
    localparam int STAT_LINE3_BIT = 2;
    localparam int STAT_FOUR_LINE_BIT = 3;

    // latency 1000, everything else off
    localparam logic [7:0] CFG_FACTORY_DEFAULT = 8'h08;

    localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
    localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;
    localparam logic [2:0] LINES_ONE = 3'h1;
    localparam logic [2:0] LINES_FOUR = 3'h4;
    localparam logic [5:0] CLOCKS_PER_BYTE_ONE = 6'h08;
    localparam logic [5:0] CLOCKS_PER_BYTE_FOUR = 6'h02;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ADDR,
        SEQ_DUMMY,
        SEQ_DATA
    } seq_state_t;

    function automatic logic [2:0] addr_byte_count(input logic long_addr);
        addr_byte_count = long_addr ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
    endfunction

    // serial clocks needed for the whole address phase
    function automatic logic [5:0] addr_clock_count(input logic long_addr, input logic four_lines);
        logic [5:0] per_byte;
        per_byte = four_lines ? CLOCKS_PER_BYTE_FOUR : CLOCKS_PER_BYTE_ONE;
        addr_clock_count = long_addr ? (per_byte << 2) : ((per_byte << 1) + per_byte);
    endfunction
endpackage

/* File: core/link_pins_if.sv */
// filtered link pin levels and serial clock edge handed from synchroniser to core
interface link_pins_if;
    logic cs_n;
    logic line3;
    logic sck_rise;

    modport sync_side (
        output cs_n,
        output line3,
        output sck_rise
    );
    modport core_side (
        input cs_n,
        input line3,
        input sck_rise
    );
endinterface

/* File: core/link_pin_sync.sv */
// three-stage synchroniser and agreement filter for the link pins
module link_pin_sync
    import flash_cfg2_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_line3,
    link_pins_if.sync_side pins
);
    // bit 0 sck, bit 1 chip select, bit 2 line 3
    logic [2:0] stage1_reg;
    logic [2:0] stage2_reg;
    logic [2:0] stage3_reg;
    logic [2:0] level_reg;
    logic sck_rise_reg;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            stage1_reg <= 3'h6;
            stage2_reg <= 3'h6;
            stage3_reg <= 3'h6;
        end else begin
            stage1_reg <= {i_line3, i_cs_n, i_sck};
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a level moves only once the last two stages agree, so one metastable sample cannot glitch it
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            level_reg <= 3'h6;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_reg[i] <= stage3_reg[i];
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            sck_rise_reg <= 1'b0;
        end else begin
            sck_rise_reg <= (stage2_reg[0] == stage3_reg[0]) && stage3_reg[0] && !level_reg[0];
        end
    end

    assign pins.sck_rise = sck_rise_reg;
    assign pins.cs_n = level_reg[1];
    assign pins.line3 = level_reg[2];
endmodule

/* File: core/flash_config_register_two.sv */
// second configuration register: nonvolatile and volatile copies, pin roles and read sequencing
module flash_config_register_two
    import flash_cfg2_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_line3_or_reset_pin,
    input wire logic i_quad_data_select,
    input wire logic i_addr_start,
    input wire logic i_addr_four_lines,
    input wire logic i_variable_latency,
    output logic [2:0] o_addr_bytes,
    output logic [2:0] o_opcode_lines,
    output logic [2:0] o_addr_lines,
    output logic [2:0] o_data_lines,
    output logic o_legacy_protocol,
    output logic o_wp_as_line2,
    output logic o_line3_as_data,
    output logic [3:0] o_dummy_cycles,
    output logic o_addr_phase,
    output logic o_dummy_phase,
    output logic o_data_phase,
    output logic o_hw_reset
);
    link_pins_if pins ();

    link_pin_sync u_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_line3(i_line3_or_reset_pin),
        .pins(pins.sync_side)
    );

    logic [7:0] cfg_nonvolatile_reg;
    logic [7:0] cfg_volatile_reg;
    logic reset_seen_reg;
    logic [31:0] rdata_reg;
    seq_state_t seq_reg;
    seq_state_t seq_next;
    logic [5:0] count_reg;
    logic [5:0] count_next;
    logic hw_reset_reg;
    logic hw_reset_req;
    logic four_line_mode;
    logic all_quad;
    logic long_addr;
    logic share_enable;
    logic [3:0] latency;
    logic addr_four;
    logic wr_nonvolatile;
    logic wr_volatile;
    logic wr_status;
    logic [2:0] addr_bytes_reg;
    logic [2:0] opcode_lines_reg;
    logic [2:0] addr_lines_reg;
    logic [2:0] data_lines_reg;
    logic legacy_reg;
    logic wp_line2_reg;
    logic line3_data_reg;
    logic [3:0] dummy_reg;
    logic [31:0] rdata_next;
    logic addr_phase_reg;
    logic dummy_phase_reg;
    logic data_phase_reg;

    // the volatile copy alone steers the live behaviour
    assign long_addr = cfg_volatile_reg[ADDR_LEN_BIT];
    assign all_quad = cfg_volatile_reg[ALL_QUAD_BIT];
    assign share_enable = cfg_volatile_reg[RESET_SHARE_BIT];
    assign latency = cfg_volatile_reg[LATENCY_LSB +: LATENCY_W];
    assign four_line_mode = all_quad || i_quad_data_select;
    assign addr_four = all_quad || i_addr_four_lines;

    assign wr_nonvolatile = i_wr && (i_addr == REG_NONVOLATILE_OFS);
    assign wr_volatile = i_wr && (i_addr == REG_VOLATILE_OFS);
    assign wr_status = i_wr && (i_addr == REG_STATUS_OFS);

    // as a plain reset pin line 3 resets whatever chip select does; in four-line mode only with the share bit set and chip select high
    always_comb begin
        if (four_line_mode) begin
            hw_reset_req = share_enable && pins.cs_n && !pins.line3;
        end else begin
            hw_reset_req = !pins.line3;
        end
    end

    // nonvolatile copy only returns to factory value under power-up reset
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cfg_nonvolatile_reg <= CFG_FACTORY_DEFAULT;
        end else if (wr_nonvolatile) begin
            cfg_nonvolatile_reg <= i_wdata[7:0];
        end
    end

    // a pin reset overrides a software write in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cfg_volatile_reg <= CFG_FACTORY_DEFAULT;
        end else if (hw_reset_req) begin
            cfg_volatile_reg <= cfg_nonvolatile_reg;
        end else if (wr_volatile) begin
            cfg_volatile_reg <= i_wdata[7:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            hw_reset_reg <= 1'b0;
        end else begin
            hw_reset_reg <= hw_reset_req && !hw_reset_reg;
        end
    end

    // sticky, write one to clear; a new reset in the clearing cycle wins
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            reset_seen_reg <= 1'b0;
        end else if (hw_reset_req) begin
            reset_seen_reg <= 1'b1;
        end else if (wr_status && i_wdata[STAT_RESET_SEEN_BIT]) begin
            reset_seen_reg <= 1'b0;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                REG_NONVOLATILE_OFS: rdata_next = {24'h00_0000, cfg_nonvolatile_reg};
                REG_VOLATILE_OFS: rdata_next = {24'h00_0000, cfg_volatile_reg};
                REG_STATUS_OFS: rdata_next = {28'h000_0000, four_line_mode, pins.line3, pins.cs_n, reset_seen_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // read data stand for one cycle only, then fall back to zero
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // address phase, then the dummy clocks if variable latency is on and latency is nonzero, then data until chip select rises or a pin reset
    always_comb begin
        seq_next = seq_reg;
        count_next = count_reg;
        case (seq_reg)
            SEQ_IDLE: begin
                if (i_addr_start && !pins.cs_n) begin
                    seq_next = SEQ_ADDR;
                    count_next = addr_clock_count(long_addr, addr_four);
                end
            end
            SEQ_ADDR: begin
                if (pins.sck_rise) begin
                    count_next = count_reg - 6'h01;
                    if (count_reg == 6'h01) begin
                        if (i_variable_latency && (latency != 4'h0)) begin
                            seq_next = SEQ_DUMMY;
                            count_next = {2'h0, latency};
                        end else begin
                            seq_next = SEQ_DATA;
                        end
                    end
                end
            end
            SEQ_DUMMY: begin
                if (pins.sck_rise) begin
                    count_next = count_reg - 6'h01;
                    if (count_reg == 6'h01) begin
                        seq_next = SEQ_DATA;
                    end
                end
            end
            SEQ_DATA: begin
                count_next = 6'h00;
            end
            default: begin
                seq_next = SEQ_IDLE;
                count_next = 6'h00;
            end
        endcase
        if (pins.cs_n || hw_reset_req) begin
            seq_next = SEQ_IDLE;
            count_next = 6'h00;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            count_reg <= 6'h00;
        end else begin
            count_reg <= count_next;
        end
    end

    // phase flags follow the next state so they line up with the state register
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            addr_phase_reg <= 1'b0;
            dummy_phase_reg <= 1'b0;
            data_phase_reg <= 1'b0;
        end else begin
            addr_phase_reg <= (seq_next == SEQ_ADDR);
            dummy_phase_reg <= (seq_next == SEQ_DUMMY);
            data_phase_reg <= (seq_next == SEQ_DATA);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            addr_bytes_reg <= ADDR_BYTES_SHORT;
        end else begin
            addr_bytes_reg <= addr_byte_count(long_addr);
        end
    end

    // opcode width and protocol flag both come from the all-phases quad bit
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            opcode_lines_reg <= LINES_ONE;
            legacy_reg <= 1'b1;
        end else begin
            opcode_lines_reg <= all_quad ? LINES_FOUR : LINES_ONE;
            legacy_reg <= !all_quad;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            addr_lines_reg <= LINES_ONE;
        end else begin
            addr_lines_reg <= addr_four ? LINES_FOUR : LINES_ONE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            data_lines_reg <= LINES_ONE;
        end else begin
            data_lines_reg <= four_line_mode ? LINES_FOUR : LINES_ONE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wp_line2_reg <= 1'b0;
            line3_data_reg <= 1'b0;
        end else begin
            wp_line2_reg <= four_line_mode;
            line3_data_reg <= four_line_mode;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            dummy_reg <= CFG_FACTORY_DEFAULT[LATENCY_LSB +: LATENCY_W];
        end else begin
            dummy_reg <= latency;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_addr_bytes = addr_bytes_reg;
    assign o_opcode_lines = opcode_lines_reg;
    assign o_addr_lines = addr_lines_reg;
    assign o_data_lines = data_lines_reg;
    assign o_legacy_protocol = legacy_reg;
    assign o_wp_as_line2 = wp_line2_reg;
    assign o_line3_as_data = line3_data_reg;
    assign o_dummy_cycles = dummy_reg;
    assign o_addr_phase = addr_phase_reg;
    assign o_dummy_phase = dummy_phase_reg;
    assign o_data_phase = data_phase_reg;
    assign o_hw_reset = hw_reset_reg;
endmodule

/* File: testbench/flash_cfg2_checker.sv */
// concurrent checks on the ports of the second configuration register
module flash_cfg2_checker (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [2:0] o_addr_bytes,
    input wire logic [2:0] o_opcode_lines,
    input wire logic [2:0] o_addr_lines,
    input wire logic [2:0] o_data_lines,
    input wire logic o_legacy_protocol,
    input wire logic o_wp_as_line2,
    input wire logic o_line3_as_data,
    input wire logic [3:0] o_dummy_cycles,
    input wire logic o_addr_phase,
    input wire logic o_dummy_phase,
    input wire logic o_data_phase,
    input wire logic o_hw_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // outputs lag the volatile copy by one cycle, so a write shows two edges on
    wire logic vol_wr = i_wr && i_addr == 4'h4;

    a_addr_len_follow: assert property (vol_wr |-> ##2 o_addr_bytes == ($past(i_wdata[7], 2) ? 3'h4 : 3'h3))
        else $error("address byte count does not follow the written bit");
    a_quad_all_lines: assert property (!o_legacy_protocol |-> o_opcode_lines == 3'h4 && o_addr_lines == 3'h4 && o_data_lines == 3'h4)
        else $error("all-phases quad without four lines everywhere");
    a_legacy_follow: assert property (vol_wr |-> ##2 o_legacy_protocol == !$past(i_wdata[6], 2))
        else $error("protocol select does not follow the written bit");
    a_pin_roles: assert property (o_wp_as_line2 == o_line3_as_data && o_data_lines == (o_wp_as_line2 ? 3'h4 : 3'h1))
        else $error("pin roles disagree with the data width");
    a_latency_follow: assert property (vol_wr |-> ##2 o_dummy_cycles == $past(i_wdata[3:0], 2))
        else $error("dummy count does not follow the latency field");
    a_reset_pulse_short: assert property (o_hw_reset |=> !o_hw_reset)
        else $error("hardware reset pulse longer than one cycle");
    a_phases_exclusive: assert property ($onehot0({o_addr_phase, o_dummy_phase, o_data_phase}))
        else $error("more than one read phase active");
    a_dummy_to_data: assert property ($fell(o_dummy_phase) |-> o_data_phase || o_hw_reset || $past(o_hw_reset))
        else $error("dummy phase not followed by data");
    a_rdata_one_cycle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_rdata_upper_zero: assert property ($past(i_rd) |-> o_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
endmodule

bind flash_config_register_two flash_cfg2_checker chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_addr_bytes(o_addr_bytes),
    .o_opcode_lines(o_opcode_lines), .o_addr_lines(o_addr_lines), .o_data_lines(o_data_lines),
    .o_legacy_protocol(o_legacy_protocol), .o_wp_as_line2(o_wp_as_line2), .o_line3_as_data(o_line3_as_data),
    .o_dummy_cycles(o_dummy_cycles), .o_addr_phase(o_addr_phase), .o_dummy_phase(o_dummy_phase),
    .o_data_phase(o_data_phase), .o_hw_reset(o_hw_reset));

/* File: testbench/host_link_model.sv */
// host side of the serial link: chip select, serial clock and line 3
module host_link_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_line3
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_line3 = 1'b1;
    end
    task automatic select(input logic lvl);
        o_cs_n = lvl;
    endtask
    // serial clock stands low outside frames
    task automatic clocks(input int n);
        repeat (n) begin
            #62.5 o_sck = 1'b1;
            #62.5 o_sck = 1'b0;
        end
    endtask
    // line 3 is pulled up; low only while a reset is requested
    task automatic pull_line3(input int t);
        o_line3 = 1'b0;
        #(t) o_line3 = 1'b1;
    endtask
endmodule

/* File: testbench/flash_config_register_two_tb.sv */
// self-checking bench for the second configuration register
module flash_config_register_two_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_mclk, i_reset, i_wr, i_rd, i_sck, i_cs_n, i_line3_or_reset_pin;
    logic i_quad_data_select, i_addr_start, i_addr_four_lines, i_variable_latency;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [2:0] o_addr_bytes, o_opcode_lines, o_addr_lines, o_data_lines;
    logic o_legacy_protocol, o_wp_as_line2, o_line3_as_data, o_addr_phase, o_dummy_phase, o_data_phase, o_hw_reset;
    logic [3:0] o_dummy_cycles;
    int failures = 0;
    int samples_checked = 0;
    int hw_resets = 0;

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    flash_config_register_two DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(i_sck), .i_cs_n(i_cs_n),
        .i_line3_or_reset_pin(i_line3_or_reset_pin), .i_quad_data_select(i_quad_data_select),
        .i_addr_start(i_addr_start), .i_addr_four_lines(i_addr_four_lines), .i_variable_latency(i_variable_latency),
        .o_addr_bytes(o_addr_bytes), .o_opcode_lines(o_opcode_lines), .o_addr_lines(o_addr_lines),
        .o_data_lines(o_data_lines), .o_legacy_protocol(o_legacy_protocol), .o_wp_as_line2(o_wp_as_line2),
        .o_line3_as_data(o_line3_as_data), .o_dummy_cycles(o_dummy_cycles), .o_addr_phase(o_addr_phase),
        .o_dummy_phase(o_dummy_phase), .o_data_phase(o_data_phase), .o_hw_reset(o_hw_reset));
    host_link_model host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_line3(i_line3_or_reset_pin));

    always @(posedge i_mclk) if (o_hw_reset === 1'b1) hw_resets <= hw_resets + 1;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= {24'h0, d};
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_rdata, e);
    endtask
    task automatic cfg_chk(input logic [2:0] ab, input logic leg, input logic wp, input logic [3:0] dc);
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({o_addr_bytes, o_legacy_protocol, o_wp_as_line2, o_line3_as_data, o_dummy_cycles}, {ab, leg, wp, wp, dc});
        chk({o_opcode_lines, o_addr_lines, o_data_lines}, leg ? 9'h049 : 9'h124);
    endtask
    task automatic ph(input logic [2:0] e);
        @(negedge i_mclk);
        chk({o_addr_phase, o_dummy_phase, o_data_phase}, e);
    endtask

    task automatic t_defaults();
        rd(4'h0, 32'h08);
        rd(4'h4, 32'h08);
        cfg_chk(3'h3, 1'b1, 1'b0, 4'h8);
    endtask
    task automatic t_fields();
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            // reserved bit always written as zero
            d = {i[0], i[1], 2'h0, i[3:0]};
            wr(4'h4, d);
            cfg_chk(d[7] ? 3'h4 : 3'h3, !d[6], d[6], d[3:0]);
            rd(4'h4, {24'h0, d});
        end
        wr(4'h0, 8'hA3);
        rd(4'h0, 32'hA3);
        wr(4'hC, 8'hFF);
        rd(4'hC, 32'h0);
    endtask
    task automatic seq(input logic [7:0] d, input logic af, input int addr_clks, input int lat);
        wr(4'h4, d);
        host.select(1'b0);
        repeat (8) @(posedge i_mclk);
        i_addr_four_lines <= af;
        i_addr_start <= 1'b1;
        @(posedge i_mclk);
        i_addr_start <= 1'b0;
        ph(3'h4);
        host.clocks(addr_clks - 1);
        ph(3'h4);
        host.clocks(1);
        ph(lat != 0 ? 3'h2 : 3'h1);
        host.clocks(lat);
        ph(3'h1);
        host.select(1'b1);
        repeat (8) @(posedge i_mclk);
        ph(3'h0);
    endtask
    task automatic t_reads();
        seq(8'h04, 1'b0, 24, 4);
        seq(8'hC2, 1'b1, 8, 2);
        seq(8'h80, 1'b0, 32, 0);
        seq(8'h4F, 1'b1, 6, 15);
        seq(8'h08, 1'b1, 6, 8);
        @(posedge i_mclk);
        i_variable_latency <= 1'b0;
        seq(8'h08, 1'b0, 24, 0);
        @(posedge i_mclk);
        i_variable_latency <= 1'b1;
    endtask
    task automatic pin(input logic [7:0] v, input logic qd, input logic cs, input logic e);
        int n;
        wr(4'h4, v);
        i_quad_data_select <= qd;
        host.select(cs);
        n = hw_resets;
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        chk(o_wp_as_line2, v[6] | qd);
        host.pull_line3(100);
        repeat (8) @(posedge i_mclk);
        host.select(1'b1);
        chk(hw_resets != n, e);
        rd(4'h4, e ? 32'hA3 : {24'h0, v});
    endtask
    task automatic t_pins();
        pin(8'h60, 1'b0, 1'b1, 1'b1);
        pin(8'h60, 1'b0, 1'b0, 1'b0);
        pin(8'h40, 1'b0, 1'b1, 1'b0);
        pin(8'h20, 1'b1, 1'b1, 1'b1);
        pin(8'h00, 1'b0, 1'b0, 1'b1);
        rd(4'h8, 32'h7);
        wr(4'h8, 8'h01);
        rd(4'h8, 32'h6);
    endtask

    task automatic report_and_stop();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // the longest path is the serial reads, under two thousand cycles
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end
    initial begin
        i_reset = 1'b1;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_quad_data_select = 1'b0;
        i_addr_start = 1'b0;
        i_addr_four_lines = 1'b0;
        i_variable_latency = 1'b1;
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_defaults();
        t_fields();
        t_reads();
        t_pins();
        report_and_stop();
    end
endmodule
